// ===== logic/esc_consts.vh
`ifndef ESC_CONSTS_VH
`define ESC_CONSTS_VH

// ****************************************************************
// register map
// ****************************************************************
`define ESC_ADDR_W          8
`define ESC_DATA_W          8
`define ESC_EXCITATION_SETUP_ADDR  8'h09
`define ESC_EXCITATION_SETUP_RST   8'h03
`define ESC_UNMAPPED_DATA   8'h00

// ****************************************************************
// field positions in excitation_setup
// ****************************************************************
`define ESC_BIT_CLK_HALVE   7
`define ESC_BIT_ALWAYS_ON   6
`define ESC_BIT_B_TRUE      5
`define ESC_BIT_B_INV       4
`define ESC_BIT_A_TRUE      3
`define ESC_BIT_A_INV       2
`define ESC_LVL_HI          1
`define ESC_LVL_LO          0

// ****************************************************************
// level codes and pin levels, in eighths of the supply
// ****************************************************************
`define ESC_LVL_CODE_8TH    2'h0
`define ESC_LVL_CODE_4TH    2'h1
`define ESC_LVL_CODE_3_8TH  2'h2
`define ESC_LVL_CODE_HALF   2'h3
`define ESC_SWING_8TH       4'h1
`define ESC_SWING_4TH       4'h2
`define ESC_SWING_3_8TH     4'h3
`define ESC_SWING_HALF      4'h4
`define ESC_MID_LEVEL       4'h4

// ****************************************************************
// timing: mclk cycles per modulator tick, ticks per excitation half
// ****************************************************************
`define ESC_MOD_DIV_W       4
`define ESC_MOD_DIV_LAST    4'h3
`define ESC_EXC_DIV_W       4
`define ESC_EXC_HALF_LAST   4'h7
`define ESC_CNT_ONE4        4'h1

`endif

// ===== logic/esc_excitation_setup.v
// What this block does
// - Setup register sits at pointer 0x09 and resets to 0x03.
// - Bit 7 set halves both excitation and modulator clock rates.
// - Bit 7 set doubles conversion time on every channel.
// - Bit 6 selects when excitation is present on enabled pins.
// - Bit 5 drives true, bit 4 inverted excitation on pin B.
// - Bit 3 drives true, bit 2 inverted excitation on pin A.
`timescale 1ns/10ps
`include "esc_consts.vh"

module esc_excitation_setup (
  // clock and reset
  input  wire                       mclk,
  input  wire                       reset_n,
  // register port from the serial interface decoder
  input  wire [`ESC_ADDR_W-1:0]     reg_addr,
  input  wire                       reg_wr,
  input  wire [`ESC_DATA_W-1:0]     reg_wdata,
  input  wire                       reg_rd,
  output reg  [`ESC_DATA_W-1:0]     reg_rdata,
  output reg                        reg_rvalid,
  // conversion state from the sequencer
  input  wire                       cap_conv_active,
  input  wire                       vt_conv_active,
  // modulator timing
  output reg                        mod_clk_en,
  output reg                        conv_time_x2,
  // excitation pin A
  output reg                        exc_pin_a_out,
  output reg                        exc_pin_a_oe,
  // excitation pin B
  output reg                        exc_pin_b_out,
  output reg                        exc_pin_b_oe,
  // excitation level to the analog driver
  output reg  [3:0]                 exc_low_level,
  output reg  [3:0]                 exc_high_level,
  output reg                        exc_rail_to_rail,
  output reg                        exc_active
);

  // ****************************************************************
  // functions
  // ****************************************************************

  // swing in eighths of supply for a level code
  function [3:0] esc_swing;
    input [1:0] code;
    begin
      case (code)
        `ESC_LVL_CODE_8TH:   esc_swing = `ESC_SWING_8TH;
        `ESC_LVL_CODE_4TH:   esc_swing = `ESC_SWING_4TH;
        `ESC_LVL_CODE_3_8TH: esc_swing = `ESC_SWING_3_8TH;
        `ESC_LVL_CODE_HALF:  esc_swing = `ESC_SWING_HALF;
        default:             esc_swing = `ESC_SWING_8TH;
      endcase
    end
  endfunction

  // drive value of one pin from its true and inverted enables
  function esc_pin_value;
    input true_en;
    input inv_en;
    input phase;
    begin
      if (true_en) begin
        esc_pin_value = phase;
      end else if (inv_en) begin
        esc_pin_value = ~phase;
      end else begin
        esc_pin_value = 1'b0;
      end
    end
  endfunction

  // ****************************************************************
  // setup register
  // ****************************************************************

  reg  [`ESC_DATA_W-1:0]     excitation_setup;
  wire                       setup_hit;
  wire                       clock_halve_sel;
  wire                       excite_always_on;
  wire [1:0]                 exc_pin_b_enable;
  wire [1:0]                 exc_pin_a_enable;
  wire                       exc_level_sel_hi;
  wire                       exc_level_sel_lo;

  assign setup_hit = (reg_addr == `ESC_EXCITATION_SETUP_ADDR);

  // field views of the register
  assign clock_halve_sel  = excitation_setup[`ESC_BIT_CLK_HALVE];
  assign excite_always_on = excitation_setup[`ESC_BIT_ALWAYS_ON];
  assign exc_pin_b_enable = {excitation_setup[`ESC_BIT_B_TRUE],
                             excitation_setup[`ESC_BIT_B_INV]};
  assign exc_pin_a_enable = {excitation_setup[`ESC_BIT_A_TRUE],
                             excitation_setup[`ESC_BIT_A_INV]};
  assign exc_level_sel_hi = excitation_setup[`ESC_LVL_HI];
  assign exc_level_sel_lo = excitation_setup[`ESC_LVL_LO];

  // write port, reset to the power-on value
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      excitation_setup <= `ESC_EXCITATION_SETUP_RST;
    end else if (reg_wr && setup_hit) begin
      excitation_setup <= reg_wdata;
    end
  end

  // read port: answer one cycle after the strobe, zero if unmapped
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata  <= `ESC_UNMAPPED_DATA;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd && setup_hit) begin
        reg_rdata <= excitation_setup;
      end else if (reg_rd) begin
        reg_rdata <= `ESC_UNMAPPED_DATA;
      end
    end
  end

  // ****************************************************************
  // clock halving prescaler
  // ****************************************************************

  reg                        half_phase;
  wire                       base_en;

  // with halving on, only every second mclk cycle advances the dividers
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      half_phase <= 1'b0;
    end else if (clock_halve_sel) begin
      half_phase <= ~half_phase;
    end else begin
      half_phase <= 1'b0;
    end
  end

  assign base_en = ~clock_halve_sel | half_phase;

  // ****************************************************************
  // modulator clock divider
  // ****************************************************************

  reg  [`ESC_MOD_DIV_W-1:0]  mod_cnt;
  wire                       mod_tick;

  assign mod_tick = base_en && (mod_cnt == `ESC_MOD_DIV_LAST);

  // modulator tick rate, halved with the prescaler
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mod_cnt <= {`ESC_MOD_DIV_W{1'b0}};
    end else if (mod_tick) begin
      mod_cnt <= {`ESC_MOD_DIV_W{1'b0}};
    end else if (base_en) begin
      mod_cnt <= mod_cnt + `ESC_CNT_ONE4;
    end
  end

  // modulator enable and conversion time scale, both registered
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mod_clk_en   <= 1'b0;
      conv_time_x2 <= 1'b0;
    end else begin
      mod_clk_en   <= mod_tick;
      conv_time_x2 <= clock_halve_sel;
    end
  end

  // ****************************************************************
  // excitation waveform
  // ****************************************************************

  reg  [`ESC_EXC_DIV_W-1:0]  exc_cnt;
  reg                        exc_phase;
  wire                       exc_run;

  // excitation present for capacitive, or also voltage/temperature
  assign exc_run = cap_conv_active |
                   (excite_always_on & vt_conv_active);

  // square wave derived from modulator ticks, so halving tracks both
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      exc_cnt   <= {`ESC_EXC_DIV_W{1'b0}};
      exc_phase <= 1'b0;
    end else if (!exc_run) begin
      exc_cnt   <= {`ESC_EXC_DIV_W{1'b0}};
      exc_phase <= 1'b0;
    end else if (mod_tick) begin
      if (exc_cnt == `ESC_EXC_HALF_LAST) begin
        exc_cnt   <= {`ESC_EXC_DIV_W{1'b0}};
        exc_phase <= ~exc_phase;
      end else begin
        exc_cnt <= exc_cnt + `ESC_CNT_ONE4;
      end
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************

  reg                        next_a_out;
  reg                        next_a_oe;
  reg                        next_b_out;
  reg                        next_b_oe;

  // true enable wins if software sets both, pins float when idle
  always @* begin
    next_a_oe  = exc_run & (exc_pin_a_enable[1] | exc_pin_a_enable[0]);
    next_b_oe  = exc_run & (exc_pin_b_enable[1] | exc_pin_b_enable[0]);
    next_a_out = next_a_oe &
                 esc_pin_value(exc_pin_a_enable[1],
                               exc_pin_a_enable[0], exc_phase);
    next_b_out = next_b_oe &
                 esc_pin_value(exc_pin_b_enable[1],
                               exc_pin_b_enable[0], exc_phase);
  end

  // register the pin outputs
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      exc_pin_a_out <= 1'b0;
      exc_pin_a_oe  <= 1'b0;
      exc_pin_b_out <= 1'b0;
      exc_pin_b_oe  <= 1'b0;
      exc_active    <= 1'b0;
    end else begin
      exc_pin_a_out <= next_a_out;
      exc_pin_a_oe  <= next_a_oe;
      exc_pin_b_out <= next_b_out;
      exc_pin_b_oe  <= next_b_oe;
      exc_active    <= exc_run;
    end
  end

  // ****************************************************************
  // excitation level
  // ****************************************************************

  wire [3:0]                 swing;

  assign swing = esc_swing({exc_level_sel_hi, exc_level_sel_lo});

  // pin low and high levels in eighths of supply around mid rail
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      exc_low_level    <= `ESC_MID_LEVEL;
      exc_high_level   <= `ESC_MID_LEVEL;
      exc_rail_to_rail <= 1'b0;
    end else begin
      exc_low_level    <= `ESC_MID_LEVEL - swing;
      exc_high_level   <= `ESC_MID_LEVEL + swing;
      exc_rail_to_rail <= (swing == `ESC_SWING_HALF);
    end
  end

endmodule

// ===== test/esc_props.sv
`timescale 1ns/10ps
// ****************************************************
// checker on the excitation setup ports
// ****************************************************
module esc_props (
  // clock, reset, register port
  input wire       mclk,
  input wire       reset_n,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire [7:0] reg_wdata,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       reg_rvalid,
  // conversion state and outputs
  input wire       cap_conv_active,
  input wire       vt_conv_active,
  input wire       mod_clk_en,
  input wire       conv_time_x2,
  input wire       exc_pin_a_out,
  input wire       exc_pin_a_oe,
  input wire       exc_pin_b_out,
  input wire       exc_pin_b_oe,
  input wire [3:0] exc_low_level,
  input wire [3:0] exc_high_level,
  input wire       exc_rail_to_rail,
  input wire       exc_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // register write, lone read, idle state
  sequence s_wr; reg_wr && reg_addr == 8'h09 && !reg_rd; endsequence
  sequence s_rd; reg_rd ##1 !reg_rd; endsequence
  sequence s_idle; !cap_conv_active && !vt_conv_active; endsequence
  AST_WR_RD: assert property (s_wr ##1 (reg_rd && reg_addr == 8'h09)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback wrong");
  AST_RVALID: assert property (s_rd |-> reg_rvalid ##1 !reg_rvalid)
    else $error("rvalid not one pulse");
  AST_UNMAPPED: assert property (reg_rd && reg_addr != 8'h09
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  AST_MOD_GAP: assert property (mod_clk_en |=> !mod_clk_en [*3])
    else $error("tick too soon");
  AST_MOD_MAX: assert property (mod_clk_en |-> ##[1:8] mod_clk_en)
    else $error("tick too late");
  AST_IDLE: assert property (s_idle |=> !exc_pin_a_oe && !exc_pin_b_oe
    && !exc_active) else $error("drive without conversion");
  AST_OE_ACT: assert property (exc_pin_a_oe || exc_pin_b_oe
    |-> exc_active) else $error("drive outside window");
  AST_OUT_A: assert property (!exc_pin_a_oe |-> !exc_pin_a_out)
    else $error("pin a out while undriven");
  AST_OUT_B: assert property (!exc_pin_b_oe |-> !exc_pin_b_out)
    else $error("pin b out while undriven");
  AST_LVL_SUM: assert property ({1'b0, exc_low_level}
    + {1'b0, exc_high_level} == 5'h08) else $error("levels not centred");
  AST_RAIL: assert property (exc_rail_to_rail ==
    (exc_low_level == 4'h0)) else $error("rail flag wrong");
endmodule

bind esc_excitation_setup esc_props u_props (.mclk(mclk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .cap_conv_active(cap_conv_active),
  .vt_conv_active(vt_conv_active), .mod_clk_en(mod_clk_en),
  .conv_time_x2(conv_time_x2), .exc_pin_a_out(exc_pin_a_out),
  .exc_pin_a_oe(exc_pin_a_oe), .exc_pin_b_out(exc_pin_b_out),
  .exc_pin_b_oe(exc_pin_b_oe), .exc_low_level(exc_low_level),
  .exc_high_level(exc_high_level), .exc_rail_to_rail(exc_rail_to_rail),
  .exc_active(exc_active));

// ===== test/esc_sensor_model.sv
`timescale 1ns/10ps
// ****************************************************
// floating capacitive sensor across both pins
// ****************************************************
module esc_sensor_model (
  // pins
  input wire mclk,
  input wire a_out,
  input wire a_oe,
  input wire b_out,
  input wire b_oe,
  // plate levels
  output reg plate_a,
  output reg plate_b
);
  initial {plate_a, plate_b} = 2'b00;
  // an undriven plate floats: it shows the inverse of its last value
  always @(posedge mclk) begin
    plate_a <= a_oe ? a_out : ~plate_a;
    plate_b <= b_oe ? b_out : ~plate_b;
  end
endmodule

// ===== test/test_excitation_setup_control.sv
`timescale 1ns/10ps
module test_excitation_setup_control;
  reg        mclk, reset_n, reg_wr, reg_rd, cap_conv_active, vt_conv_active;
  reg  [7:0] reg_addr, reg_wdata, cfg;
  wire [7:0] reg_rdata;
  wire [3:0] lo, hi;
  wire       reg_rvalid, mod_clk_en, x2, pa, pa_oe, pb, pb_oe, rail, act;
  wire       plate_a, plate_b;
  integer    fails, num_checks, i, n;
  esc_excitation_setup dut (.mclk(mclk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .cap_conv_active(cap_conv_active), .vt_conv_active(vt_conv_active),
    .mod_clk_en(mod_clk_en), .conv_time_x2(x2), .exc_pin_a_out(pa),
    .exc_pin_a_oe(pa_oe), .exc_pin_b_out(pb), .exc_pin_b_oe(pb_oe),
    .exc_low_level(lo), .exc_high_level(hi), .exc_rail_to_rail(rail),
    .exc_active(act));
  esc_sensor_model u_sensor (.mclk(mclk), .a_out(pa), .a_oe(pa_oe),
    .b_out(pb), .b_oe(pb_oe), .plate_a(plate_a), .plate_b(plate_b));
  // ****************************************************
  // shared tasks
  // ****************************************************
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      chk("rvalid", 8'h01, {7'h00, reg_rvalid});
      chk("rdata", e, reg_rdata);
    end
  endtask
  // write, then read back on the very next cycle
  task wrrd(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      chk("rvalid", 8'h01, {7'h00, reg_rvalid});
      chk("readback", d, reg_rdata);
    end
  endtask
  task run(input c, input v);
    begin
      @(posedge mclk);
      cap_conv_active <= c;
      vt_conv_active <= v;
    end
  endtask
  task pk(input integer k);
    begin
      repeat (k) @(posedge mclk);
      @(negedge mclk);
    end
  endtask
  // counts mclk cycles between two modulator ticks
  task per(input [7:0] e);
    begin
      n = 0;
      while (mod_clk_en !== 1'b1 && n < 20) begin
        @(negedge mclk);
        n = n + 1;
      end
      n = 1;
      @(negedge mclk);
      while (mod_clk_en !== 1'b1 && n < 20) begin
        @(negedge mclk);
        n = n + 1;
      end
      chk("tick period", e, n[7:0]);
    end
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  task t_reset;
    begin
      rdc(8'h09, 8'h03);
      chk("rail", 8'h01, {7'h00, rail});
      wr(8'h0A, 8'hFF);
      rdc(8'h0A, 8'h00);
      rdc(8'h09, 8'h03);
      wrrd(8'h09, 8'hC5);
      @(posedge mclk);
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rdc(8'h09, 8'h03);
      chk("x2 after reset", 8'h00, {7'h00, x2});
      chk("rail after reset", 8'h01, {7'h00, rail});
      $display("test reset done");
    end
  endtask
  task t_levels;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wrrd(8'h09, i[7:0]);
        pk(2);
        chk("low", 8'h03 - i[7:0], {4'h0, lo});
        chk("high", 8'h05 + i[7:0], {4'h0, hi});
        chk("rail", {7'h00, i == 3}, {7'h00, rail});
        rdc(8'h09, i[7:0]);
      end
      $display("test levels done");
    end
  endtask
  // true phase starts low, inverted starts high, both flip later
  task t_pins;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        cfg = (i == 0) ? 8'h18 : (i == 1) ? 8'h24 : 8'h00;
        wr(8'h09, cfg);
        run(1'b1, 1'b0);
        pk(1);
        chk("a oe", cfg[3] | cfg[2], {7'h00, pa_oe});
        chk("a out", cfg[2], {7'h00, pa});
        chk("b oe", cfg[5] | cfg[4], {7'h00, pb_oe});
        chk("b out", cfg[4], {7'h00, pb});
        pk(39);
        chk("a flip", cfg[3], {7'h00, pa});
        chk("b flip", cfg[5], {7'h00, pb});
        if (i < 2) begin
          chk("plate a", {7'h00, cfg[3]}, {7'h00, plate_a});
          chk("plate b", {7'h00, cfg[5]}, {7'h00, plate_b});
        end
        run(1'b0, 1'b0);
        pk(1);
        chk("a off", 8'h00, {7'h00, pa_oe});
        chk("b off", 8'h00, {7'h00, pb_oe});
      end
      $display("test pins done");
    end
  endtask
  task t_persist;
    begin
      wr(8'h09, 8'h08);
      run(1'b0, 1'b1);
      pk(1);
      chk("vt only oe", 8'h00, {7'h00, pa_oe});
      wr(8'h09, 8'h48);
      pk(2);
      chk("vt kept oe", 8'h01, {7'h00, pa_oe});
      chk("vt active", 8'h01, {7'h00, act});
      run(1'b0, 1'b0);
      $display("test persist done");
    end
  endtask
  task t_halve;
    begin
      wr(8'h09, 8'h88);
      run(1'b1, 1'b0);
      pk(2);
      chk("x2", 8'h01, {7'h00, x2});
      per(8'h08);
      pk(35);
      chk("slow hold", 8'h00, {7'h00, pa});
      pk(50);
      chk("slow flip", 8'h01, {7'h00, pa});
      run(1'b0, 1'b0);
      wr(8'h09, 8'h08);
      pk(2);
      chk("x1", 8'h00, {7'h00, x2});
      per(8'h04);
      $display("test halve done");
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // clock, watchdog and main sequence
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #2000000;
    fails = fails + 1;
    stop_test;
  end
  initial begin
    {reset_n, reg_wr, reg_rd, cap_conv_active, vt_conv_active} = 5'h00;
    {reg_addr, reg_wdata} = 16'h0000;
    fails = 0;
    num_checks = 0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset;
    t_levels;
    t_pins;
    t_persist;
    t_halve;
    stop_test;
  end
endmodule
